// ===== lfw_capture_timer.sv
// lfw_capture_timer: enabled count latched on each envelope edge in transparent mode.
// assumes the envelope arrives registered on pclk through the link.
`timescale 1ns/1ps
`default_nettype none
module lfw_capture_timer
	import lfw_pkg::*;
#(
	parameter int W = TMR_W
)(
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// receiver side
	lfw_tmr_if.tmr    lk
);
	if (W < 2 || W > 32)
	begin : g_chk
		$error("lfw_capture_timer: W out of range");
	end

	logic [W-1:0] count_reg, count_next;
	logic [W-1:0] cap_reg, cap_next;
	logic         pulse_reg, pulse_next;
	logic         env_prev_reg, env_prev_next;

	always_comb
	begin
		count_next    = count_reg;
		cap_next      = cap_reg;
		pulse_next    = 1'b0;
		env_prev_next = lk.envelope_out;
		// counter only runs while software keeps the timer enabled
		if (lk.tmr3_enable)
		begin
			count_next = count_reg + 1'b1;
			if (lk.transp_active && (lk.envelope_out != env_prev_reg))
			begin
				cap_next   = count_reg;
				pulse_next = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count_reg    <= '0;
			cap_reg      <= '0;
			pulse_reg    <= 1'b0;
			env_prev_reg <= 1'b0;
		end
		else
		begin
			count_reg    <= count_next;
			cap_reg      <= cap_next;
			pulse_reg    <= pulse_next;
			env_prev_reg <= env_prev_next;
		end
	end

	assign lk.cap_pulse = pulse_reg;
	assign lk.cap_val   = cap_reg;
endmodule
`default_nettype wire

// ===== lfw_lf_tx.sv
// lfw_lf_tx: remote lf transmitter feeding the front-end pins.
// assumes pclk timing; preamble and sync are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module lfw_lf_tx
(
	// clock
	input  wire logic pclk,
	// air side
	output var logic  fe_preamble,
	output var logic  fe_sync_ok,
	output var logic  fe_env
);
	initial
	begin
		fe_preamble = 1'b0;
		fe_sync_ok = 1'b0;
		fe_env = 1'b0;
	end
	// one-cycle preamble or sync pulse: well-defined start
	task automatic pulse(input bit sync);
		@(posedge pclk);
		if (sync)
			fe_sync_ok <= 1'b1;
		else
			fe_preamble <= 1'b1;
		@(posedge pclk);
		fe_sync_ok <= 1'b0;
		fe_preamble <= 1'b0;
	endtask
	// any coding, level held n cycles
	task automatic bit_out(input logic b, input int n);
		@(posedge pclk);
		fe_env <= b;
		repeat (n - 1) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

// ===== lfw_pkg.sv
// lfw_pkg: constants shared by the lf wake-up receiver and its capture timer.
// assumes a 100 MHz pclk and a 32-bit apb register bus.
package lfw_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_CONFIG  = 8'h00;
	localparam logic [7:0] OFS_CONTROL = 8'h04;
	localparam logic [7:0] OFS_STATUS  = 8'h08;
	localparam logic [7:0] OFS_MASK    = 8'h0c;
	localparam logic [7:0] OFS_STATE   = 8'h10;
	localparam logic [7:0] OFS_CAPTURE = 8'h14;

	// rx_config_reg fields
	localparam int CFG_EN_BIT    = 0;
	localparam int CFG_MODE_LO   = 1;
	localparam int CFG_BURST_BIT = 3;
	// rx_control_reg fields
	localparam int CTL_RESET_BIT = 0;
	localparam int CTL_T3EN_BIT  = 1;
	// status and mask fields
	localparam int EV_WAKE_BIT   = 0;
	localparam int EV_CAP_BIT    = 1;
	localparam int EV_COUNT      = 2;

	localparam logic [1:0] MODE_START_GAP   = 2'h0;
	localparam logic [1:0] MODE_TRANSPARENT = 2'h3;

	localparam logic [3:0] CONFIG_RESET = 4'h0;
	localparam logic       T3EN_RESET   = 1'h0;
	localparam logic [1:0] MASK_RESET   = 2'h0;

	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int GAP_MAX_NS    = 2_030_000;
	localparam int GAP_MAX_CYC   = GAP_MAX_NS / CLK_PERIOD_NS;
	localparam int GAP_CNT_W     = 20;
	localparam int TMR_W         = 16;

	typedef enum logic [1:0] {
		ST_LISTEN,
		ST_WAIT_SYNC,
		ST_MAN_RX,
		ST_TRANSP
	} lfw_state_t;

endpackage

// ===== lfw_receiver.sv
// lfw_receiver: lf wake-up receiver control with transparent mode,
// apb registers and the capture timer that timestamps the envelope edges.
// assumes front-end inputs are synchronous to pclk; preamble and sync are pulses.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module lfw_receiver
	import lfw_pkg::*;
#(
	parameter int GAP_CYCLES = GAP_MAX_CYC
)(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// analog front end
	input  wire logic        fe_preamble,
	input  wire logic        fe_sync_ok,
	input  wire logic        fe_env,
	output logic             rx_listen,
	output logic             slow_rc_osc,
	output logic             envelope_out,
	// interrupts
	output logic             wake_irq,
	output logic             tmr3_capture_irq,
	output logic             irq
);
	if (GAP_CYCLES < 1 || GAP_CYCLES >= (1 << GAP_CNT_W))
	begin : g_chk
		$error("lfw_receiver: GAP_CYCLES out of range");
	end
	localparam logic [GAP_CNT_W-1:0] GAP_LIMIT = GAP_CNT_W'(GAP_CYCLES);

	lfw_tmr_if #(.W(TMR_W)) lk ();

	lfw_capture_timer #(.W(TMR_W)) u_tmr (
		.pclk    (pclk),
		.presetn (presetn),
		.lk      (lk)
	);

	// register state
	logic [3:0]          cfg_reg, cfg_next;
	logic                t3en_reg, t3en_next;
	logic [EV_COUNT-1:0] stat_reg, stat_next;
	logic [EV_COUNT-1:0] mask_reg, mask_next;
	logic [31:0]         prdata_reg, prdata_next;
	logic                pready_reg, pready_next;
	logic                pslverr_reg, pslverr_next;
	logic                front_reset;

	// receiver state
	lfw_state_t             st_reg, st_next;
	logic [GAP_CNT_W-1:0]   gap_reg, gap_next;
	logic                   env_reg, env_next;
	logic                   envout_reg, envout_next;
	logic                   src_reg, src_next;
	logic                   listen_reg, listen_next;
	logic                   wirq_reg, wirq_next;
	logic                   cirq_reg, cirq_next;
	logic                   irq_reg, irq_next;
	logic                   wake_ev;

	logic       enable;
	logic [1:0] mode;
	logic       wr_access;
	assign enable    = cfg_reg[CFG_EN_BIT];
	assign mode      = cfg_reg[CFG_MODE_LO +: 2];
	assign wr_access = psel && penable && pwrite && pready_reg;

	// apb: answer one cycle into the access phase
	always_comb
	begin
		cfg_next     = cfg_reg;
		t3en_next    = t3en_reg;
		mask_next    = mask_reg;
		prdata_next  = 32'h0;
		pready_next  = 1'b0;
		pslverr_next = 1'b0;
		front_reset  = 1'b0;
		if (psel && penable && !pready_reg)
		begin
			pready_next = 1'b1;
			if (paddr == OFS_CONFIG)
				prdata_next = {28'h0, cfg_reg};
			else if (paddr == OFS_CONTROL)
				prdata_next = {30'h0, t3en_reg, 1'b0};
			else if (paddr == OFS_STATUS)
				prdata_next = {30'h0, stat_reg};
			else if (paddr == OFS_MASK)
				prdata_next = {30'h0, mask_reg};
			else if (paddr == OFS_STATE)
				prdata_next = {27'h0, envout_reg, src_reg, listen_reg, st_reg};
			else if (paddr == OFS_CAPTURE)
				prdata_next = {16'h0, lk.cap_val};
			else
				pslverr_next = 1'b1;
			// writes answer with zero read data
			if (pwrite)
				prdata_next = 32'h0;
		end
		// write lands on the edge that completes the transfer, not earlier
		if (wr_access)
		begin
			if (paddr == OFS_CONFIG)
				cfg_next = pwdata[3:0];
			else if (paddr == OFS_CONTROL)
			begin
				front_reset = pwdata[CTL_RESET_BIT];
				t3en_next   = pwdata[CTL_T3EN_BIT];
			end
			else if (paddr == OFS_MASK)
				mask_next = pwdata[EV_COUNT-1:0];
		end
	end

	// sticky events: a set in the clearing cycle wins
	always_comb
	begin
		stat_next = stat_reg;
		if (wr_access && paddr == OFS_STATUS)
			stat_next = stat_reg & ~pwdata[EV_COUNT-1:0];
		if (wake_ev)
			stat_next[EV_WAKE_BIT] = 1'b1;
		if (lk.cap_pulse)
			stat_next[EV_CAP_BIT] = 1'b1;
		wirq_next = stat_next[EV_WAKE_BIT] && mask_next[EV_WAKE_BIT];
		cirq_next = stat_next[EV_CAP_BIT] && mask_next[EV_CAP_BIT];
		irq_next  = wirq_next || cirq_next;
	end

	// receiver state machine
	always_comb
	begin
		st_next  = st_reg;
		gap_next = gap_reg;
		env_next = fe_env;
		wake_ev  = 1'b0;
		case (st_reg)
			ST_LISTEN:
			begin
				gap_next = '0;
				if (enable && fe_preamble)
				begin
					// burst select plays no part here
					if (mode == MODE_TRANSPARENT)
						st_next = ST_TRANSP;
					else
						st_next = ST_WAIT_SYNC;
				end
			end
			ST_WAIT_SYNC:
			begin
				gap_next = gap_reg + 1'b1;
				if (mode == MODE_TRANSPARENT)
					st_next = ST_TRANSP;
				else if (fe_sync_ok)
				begin
					st_next  = ST_MAN_RX;
					gap_next = '0;
					wake_ev  = 1'b1;
				end
				else if (gap_reg >= GAP_LIMIT)
					st_next = ST_LISTEN;
			end
			ST_MAN_RX:
			begin
				gap_next = (fe_env != env_reg) ? '0 : gap_reg + 1'b1;
				// software may switch to transparent from the wake handler
				if (mode == MODE_TRANSPARENT)
					st_next = ST_TRANSP;
				else if (gap_reg >= GAP_LIMIT)
					st_next = ST_LISTEN;
			end
			ST_TRANSP:
			begin
				// no automatic exit: software ends the frame
				gap_next = '0;
			end
			default:
				st_next = ST_LISTEN;
		endcase
		if (!enable && st_reg != ST_LISTEN)
			st_next = ST_LISTEN;
		if (front_reset)
			st_next = ST_LISTEN;
	end

	// outputs follow the next state so they change with it
	always_comb
	begin
		listen_next = (st_next == ST_LISTEN);
		src_next    = (st_next != ST_LISTEN);
		// raw envelope, no decoding, so any code or rate passes
		envout_next = (st_next == ST_TRANSP) && fe_env;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_reg     <= CONFIG_RESET;
			t3en_reg    <= T3EN_RESET;
			mask_reg    <= MASK_RESET;
			stat_reg    <= '0;
			prdata_reg  <= 32'h0;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			st_reg      <= ST_LISTEN;
			gap_reg     <= '0;
			env_reg     <= 1'b0;
			envout_reg  <= 1'b0;
			src_reg     <= 1'b0;
			listen_reg  <= 1'b1;
			wirq_reg    <= 1'b0;
			cirq_reg    <= 1'b0;
			irq_reg     <= 1'b0;
		end
		else
		begin
			cfg_reg     <= cfg_next;
			t3en_reg    <= t3en_next;
			mask_reg    <= mask_next;
			stat_reg    <= stat_next;
			prdata_reg  <= prdata_next;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
			st_reg      <= st_next;
			gap_reg     <= gap_next;
			env_reg     <= env_next;
			envout_reg  <= envout_next;
			src_reg     <= src_next;
			listen_reg  <= listen_next;
			wirq_reg    <= wirq_next;
			cirq_reg    <= cirq_next;
			irq_reg     <= irq_next;
		end
	end

	// timer link
	assign lk.envelope_out  = envout_reg;
	assign lk.tmr3_enable   = t3en_reg;
	assign lk.transp_active = (st_reg == ST_TRANSP);

	assign prdata           = prdata_reg;
	assign pready           = pready_reg;
	assign pslverr          = pslverr_reg;
	assign rx_listen        = listen_reg;
	assign slow_rc_osc      = src_reg;
	assign envelope_out     = envout_reg;
	assign wake_irq         = wirq_reg;
	assign tmr3_capture_irq = cirq_reg;
	assign irq              = irq_reg;
endmodule
`default_nettype wire

// ===== lfw_receiver_asserts.sv
// lfw_receiver_asserts: port checks of the lf wake-up receiver.
// assumes a bind onto lfw_receiver; one pclk domain.
`timescale 1ns/1ps
`default_nettype none
module lfw_receiver_asserts
	import lfw_pkg::*;
(
	// clock, reset and apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// front end and interrupts
	input wire logic        fe_env,
	input wire logic        rx_listen,
	input wire logic        slow_rc_osc,
	input wire logic        envelope_out,
	input wire logic        wake_irq,
	input wire logic        tmr3_capture_irq,
	input wire logic        irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_taken;
		psel && penable && !pready;
	endsequence
	sequence s_fe_reset;
		s_taken ##0 (pwrite && paddr == OFS_CONTROL && pwdata[CTL_RESET_BIT]);
	endsequence
	a_apb_answer: assert property (s_taken |=> pready) else $error("no answer");
	a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
	a_err_pair: assert property (pslverr |-> pready) else $error("stray error");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("rdata idle");
	a_osc_awake: assert property (slow_rc_osc == !rx_listen) else $error("osc");
	a_env_quiet: assert property (rx_listen |-> !envelope_out) else $error("env");
	a_env_follow: assert property ($changed(envelope_out) && !rx_listen
		|-> envelope_out == $past(fe_env)) else $error("env copy");
	a_front_reset: assert property (s_fe_reset |-> ##[1:3] rx_listen)
		else $error("no listen");
	a_irq_merge: assert property (irq == (wake_irq || tmr3_capture_irq)) else $error("irq");
endmodule
`default_nettype wire

// ===== lfw_receiver_tb.sv
// lfw_receiver_tb: self-checking bench for the lf wake-up receiver.
// assumes the package, checker and transmitter model compile first.
`timescale 1ns/1ps
`default_nettype none
module lfw_receiver_tb
	import lfw_pkg::*;
;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d, e; logic s;} lfw_row_t;
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [15:0] cap [2];
	int          stamp [2];
	int          cyc = 0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, err, fe_preamble, fe_sync_ok, fe_env, rx_listen;
	logic        slow_rc_osc, envelope_out, wake_irq, tmr3_capture_irq, irq;
	int          error_cnt = 0;
	int          compares = 0;
	lfw_row_t    rows [8] = '{
		'{1'b0, OFS_CONFIG, 32'h0, 32'h0, 1'b0},
		'{1'b0, OFS_CONTROL, 32'h0, 32'h0, 1'b0},
		'{1'b0, OFS_STATE, 32'h0, 32'h4, 1'b0},
		'{1'b1, 8'h18, 32'h1, 32'h0, 1'b1},
		'{1'b0, 8'h18, 32'h0, 32'h0, 1'b1},
		'{1'b1, OFS_MASK, 32'h3, 32'h0, 1'b0},
		'{1'b0, OFS_MASK, 32'h0, 32'h3, 1'b0},
		'{1'b1, OFS_CONFIG, 32'hf, 32'h0, 1'b0}};
	always #5 pclk = ~pclk;
	always @(posedge pclk) cyc <= cyc + 1;
	lfw_receiver #(.GAP_CYCLES(50)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .fe_preamble, .fe_sync_ok, .fe_env, .rx_listen,
		.slow_rc_osc, .envelope_out, .wake_irq, .tmr3_capture_irq, .irq);
	lfw_lf_tx tx (.pclk, .fe_preamble, .fe_sync_ok, .fe_env);
	task automatic final_report();
		if (error_cnt == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic fail(input string m);
		error_cnt++;
		$display("ERROR %0t %s", $time, m);
	endtask
	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
			fail($sformatf("data %h want %h", g, e));
	endtask
	task automatic chk1(input logic g, input logic e);
		compares++;
		if (g !== e)
			fail("flag mismatch");
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			fail("apb hang");
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_on(ref logic s, input logic v);
		int n;
		for (n = 0; n < 200 && s !== v; n++)
			@(posedge pclk);
		if (s !== v)
		begin
			fail("wait timeout");
			final_report();
		end
	endtask
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		chk1(rx_listen, 1'b1);
		foreach (rows[i])
		begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			chk1(err, rows[i].s);
			if (!rows[i].w)
				chk32(rd, rows[i].e);
		end
		apb(1'b1, OFS_CONTROL, 32'h2);
		apb(1'b1, OFS_MASK, 32'h2);
		tx.pulse(1'b0);
		wait_on(rx_listen, 1'b0);
		chk1(slow_rc_osc, 1'b1);
		apb(1'b0, OFS_STATE, 32'h0);
		chk32(rd, 32'hb);
		for (int k = 0; k < 2; k++)
		begin
			stamp[k] = cyc;
			tx.bit_out(k == 0, 8);
			chk1(envelope_out, k == 0);
			wait_on(tmr3_capture_irq, 1'b1);
			apb(1'b0, OFS_STATUS, 32'h0);
			chk32(rd, 32'h2);
			apb(1'b0, OFS_CAPTURE, 32'h0);
			cap[k] = rd[15:0];
			apb(1'b1, OFS_STATUS, 32'h2);
			@(posedge pclk);
			chk1(irq, 1'b0);
		end
		// captured counts lie apart by the cycles between envelope edges
		chk32({16'h0, cap[1] - cap[0]}, 32'(stamp[1] - stamp[0]));
		apb(1'b1, OFS_CONTROL, 32'h3);
		wait_on(rx_listen, 1'b1);
		apb(1'b0, OFS_CONTROL, 32'h0);
		chk32(rd, 32'h2);
		apb(1'b1, OFS_MASK, 32'h2);
		apb(1'b1, OFS_CONFIG, 32'h1);
		tx.pulse(1'b0);
		tx.pulse(1'b1);
		repeat (3) @(posedge pclk);
		chk1(wake_irq, 1'b0);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk32(rd, 32'h1);
		apb(1'b1, OFS_MASK, 32'h3);
		@(posedge pclk);
		chk1(wake_irq, 1'b1);
		apb(1'b1, OFS_CONFIG, 32'h7);
		apb(1'b0, OFS_STATE, 32'h0);
		chk32(rd, 32'hb);
		apb(1'b1, OFS_MASK, 32'h2);
		@(posedge pclk);
		chk1(wake_irq, 1'b0);
		apb(1'b1, OFS_CONTROL, 32'h1);
		wait_on(rx_listen, 1'b1);
		apb(1'b1, OFS_CONFIG, 32'h1);
		apb(1'b1, OFS_STATUS, 32'h3);
		tx.pulse(1'b0);
		tx.pulse(1'b1);
		repeat (30) @(posedge pclk);
		chk1(rx_listen, 1'b0);
		wait_on(rx_listen, 1'b1);
		tx.pulse(1'b0);
		wait_on(rx_listen, 1'b0);
		apb(1'b1, OFS_CONFIG, 32'h0);
		// well before the gap limit, so only the enable clear can explain it
		repeat (2) @(posedge pclk);
		chk1(rx_listen, 1'b1);
		apb(1'b1, OFS_CONFIG, 32'h1);
		tx.pulse(1'b0);
		wait_on(rx_listen, 1'b0);
		repeat (30) @(posedge pclk);
		chk1(rx_listen, 1'b0);
		wait_on(rx_listen, 1'b1);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk1(rx_listen, 1'b1);
		apb(1'b0, OFS_MASK, 32'h0);
		chk32(rd, 32'h0);
		final_report();
	end
endmodule
bind lfw_receiver lfw_receiver_asserts chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .fe_env, .rx_listen, .slow_rc_osc,
	.envelope_out, .wake_irq, .tmr3_capture_irq, .irq);
`default_nettype wire

// ===== lfw_tmr_if.sv
// lfw_tmr_if: link between the receiver and its capture timer.
// assumes both ends run on pclk.
`timescale 1ns/1ps
`default_nettype none
interface lfw_tmr_if #(parameter int W = 16);
	logic         envelope_out;
	logic         tmr3_enable;
	logic         transp_active;
	logic         cap_pulse;
	logic [W-1:0] cap_val;

	modport rx  (output envelope_out, output tmr3_enable, output transp_active,
	             input cap_pulse, input cap_val);
	modport tmr (input envelope_out, input tmr3_enable, input transp_active,
	             output cap_pulse, output cap_val);
endinterface
`default_nettype wire
